// ### src/ciwf_defines.svh
`ifndef CIWF_DEFINES_SVH
`define CIWF_DEFINES_SVH

// Process image word order
`define CIWF_IDX_CH1_DATA 2'h0
`define CIWF_IDX_CH1_STAT 2'h1
`define CIWF_IDX_CH2_DATA 2'h2
`define CIWF_IDX_CH2_STAT 2'h3

// Status word bit positions
`define CIWF_BIT_GLOBAL 0
`define CIWF_BIT_SHORT 1
`define CIWF_BIT_OVER_WARN 2
`define CIWF_BIT_OVER_ERR 3
`define CIWF_BIT_UNDER_WARN 4
`define CIWF_BIT_UNDER_ERR 5

// Data word layout: significant field and forced-zero bits
`define CIWF_DATA_MSB 14
`define CIWF_DATA_LSB 3
`define CIWF_DATA_MASK 16'h7FF8

// Count scale and thresholds
`define CIWF_FULL_SCALE 15'h7D00
`define CIWF_TOP_COUNT 16'h7FF8
`define CIWF_OVER_ERR_LEVEL 16'h8000
`define CIWF_UNDER_WARN_LEVEL 16'h0300
`define CIWF_SAT_16 16'hFFFF
`define CIWF_SAT_15 16'h7FFF

// Calibration limits
`define CIWF_MAXC_MIN 15'h5CF8
`define CIWF_MAXC_MAX 15'h7FF8
`define CIWF_AVG_MIN 4'h1
`define CIWF_AVG_MAX 4'h8

// Refresh timing
`define CIWF_REFRESH_NS 5000000
`define CIWF_CLK_PERIOD_NS 50

// Reset values
`define CIWF_ZERO_WORD 16'h0000

`endif

// ### src/ciwf_pkg.sv
`default_nettype none
package ciwf_pkg;
	// Sequencer states, one-hot
	typedef enum logic [2:0] {
		CIWF_IDLE = 3'b001,
		CIWF_DIVIDE = 3'b010,
		CIWF_STORE = 3'b100
	} ciwf_state_t;
endpackage : ciwf_pkg
`default_nettype wire

// ### src/ciwf_fifo.sv
`default_nettype none
module ciwf_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// Storage words
	logic [WIDTH-1:0] mem [DEPTH];
	// Pointers and fill level
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] fill;
	logic [AW:0] next_fill;
	logic push;
	logic pop;

	// Handshakes on both sides
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign next_fill = fill + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data = mem[rd_ptr];

	// Write side
	always_ff @(posedge core_clk) begin
		if (clk_en && push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and registered full and empty
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else if (clk_en) begin
			if (push) begin
				wr_ptr <= wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= rd_ptr + AW'(1);
			end
			fill <= next_fill;
			in_ready <= (next_fill != (AW+1)'(DEPTH));
			out_valid <= (next_fill != '0);
		end
	end
endmodule : ciwf_fifo
`default_nettype wire

// ### src/ciwf_divider.sv
`default_nettype none
module ciwf_divider #(
	parameter int NUM_W = 33,
	parameter int DEN_W = 19
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic start,
	input wire logic [NUM_W-1:0] numerator,
	input wire logic [DEN_W-1:0] denominator,
	output logic busy,
	output logic done,
	output logic [NUM_W-1:0] quotient
);
	localparam int CW = $clog2(NUM_W + 1);

	// Partial remainder, dividend shifting into quotient, divisor
	logic [DEN_W:0] rem;
	logic [NUM_W-1:0] dvd;
	logic [DEN_W-1:0] dvs;
	logic [CW-1:0] bits_left;
	logic [DEN_W:0] rem_sh;
	logic fits;
	logic [DEN_W:0] next_rem;

	// One restoring step per cycle
	assign rem_sh = {rem[DEN_W-1:0], dvd[NUM_W-1]};
	assign fits = (rem_sh >= {1'b0, dvs});
	assign next_rem = fits ? (rem_sh - {1'b0, dvs}) : rem_sh;
	assign quotient = dvd;

	// Iteration control
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rem <= '0;
			dvd <= '0;
			dvs <= '0;
			bits_left <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (clk_en) begin
			done <= 1'b0;
			if (start && !busy) begin
				rem <= '0;
				dvd <= numerator;
				dvs <= denominator;
				bits_left <= CW'(NUM_W);
				busy <= 1'b1;
			end else if (busy) begin
				rem <= next_rem;
				dvd <= {dvd[NUM_W-2:0], fits};
				bits_left <= bits_left - CW'(1);
				if (bits_left == CW'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule : ciwf_divider
`default_nettype wire

// ### src/ciwf_top.sv
// What this block does
// - Reading sits in data bits 14..3
// - Counts 0..32760 in steps of eight
// - Linear scale, 32000 counts is 20 mA
// - Data bit 15 always zero
// - Data bits 2..0 always zero
// - Words: ch1 data, ch1 status, ch2 data/status
// - Status in six low bits, rest zero
// - Global bit is short or overcurrent error
// - Bit 1 flags sensor supply short
// - Bit 2 warns above 20 mA
// - Bit 3 errors at 20.48 mA up
// - Bit 4 warns below 0.48 mA
// - Bit 5 errors at zero current
// - Supply faults reported within 15 ms
// - Offset calibration 0..8191 counts
// - Max count calibration 23800..32760
// - Both channels refreshed every 5 ms
// - Module-wide averaging over 1..8 samples
`include "ciwf_defines.svh"
`default_nettype none
module ciwf_top #(
	parameter int REFRESH_CYCLES = `CIWF_REFRESH_NS / `CIWF_CLK_PERIOD_NS,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic sample_valid,
	output logic sample_ready,
	input wire logic sample_channel,
	input wire logic [14:0] sample_count,
	input wire logic sensor_power_short_pin,
	input wire logic [12:0] offset_ch1,
	input wire logic [12:0] offset_ch2,
	input wire logic [14:0] max_count_ch1,
	input wire logic [14:0] max_count_ch2,
	input wire logic [7:0] average_samples,
	input wire logic image_rd_en,
	input wire logic [1:0] image_rd_index,
	output logic [15:0] image_rd_data,
	output logic image_rd_valid,
	output logic conversion_start
);
	localparam int NUM_W = 33;
	localparam int DEN_W = 19;
	localparam int TW = $clog2(REFRESH_CYCLES);

	// Clamp a max count setting into its legal band
	function automatic logic [14:0] ciwf_clamp_maxc(input logic [14:0] v);
		if (v < `CIWF_MAXC_MIN) begin
			return `CIWF_MAXC_MIN;
		end else if (v > `CIWF_MAXC_MAX) begin
			return `CIWF_MAXC_MAX;
		end
		return v;
	endfunction : ciwf_clamp_maxc

	// Sequencer state
	ciwf_pkg::ciwf_state_t state;
	// Short pin synchroniser
	logic short_meta;
	logic short_sync;
	// Refresh timer
	logic [TW-1:0] refresh_cnt;
	// FIFO drain side
	logic fifo_valid;
	logic fifo_ready;
	logic [15:0] fifo_data;
	logic pop;
	// Per-channel accumulation
	logic [17:0] acc_sum [2];
	logic [3:0] acc_cnt [2];
	// Decoded settings
	logic [3:0] avg_n;
	logic [12:0] offs_sel;
	logic [14:0] maxc_sel;
	// Arithmetic for the division launch
	logic pop_ch;
	logic [17:0] total;
	logic [16:0] n_offset;
	logic [17:0] net;
	logic [NUM_W-1:0] div_num;
	logic [DEN_W-1:0] div_den;
	logic last_sample;
	logic div_start;
	logic div_done;
	logic [NUM_W-1:0] div_quot;
	// Channel being converted
	logic work_ch;
	// Result shaping
	logic [15:0] full_val;
	logic [15:0] data_val;
	// Stored image per channel
	logic [15:0] data_word [2];
	logic [3:0] cond_flags [2];
	// Status words assembled from flags and the live short
	logic [15:0] stat_word [2];

	// Two-flop synchroniser for the supply short pin
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			short_meta <= 1'b0;
			short_sync <= 1'b0;
		end else if (clk_en) begin
			short_meta <= sensor_power_short_pin;
			short_sync <= short_meta;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			refresh_cnt <= '0;
			conversion_start <= 1'b0;
		end else if (clk_en) begin
			conversion_start <= (refresh_cnt == TW'(REFRESH_CYCLES - 1));
			if (refresh_cnt == TW'(REFRESH_CYCLES - 1)) begin
				refresh_cnt <= '0;
			end else begin
				refresh_cnt <= refresh_cnt + TW'(1);
			end
		end
	end

	// Raw sample buffer, word is channel and count
	ciwf_fifo #(
		.WIDTH(16),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.in_valid(sample_valid),
		.in_ready(sample_ready),
		.in_data({sample_channel, sample_count}),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data(fifo_data)
	);

	// Drain only while idle, so a busy divider backs up the buffer
	assign fifo_ready = (state == ciwf_pkg::CIWF_IDLE);
	assign pop = fifo_valid && fifo_ready;
	assign pop_ch = fifo_data[15];

	always_comb begin
		if (average_samples < 8'(`CIWF_AVG_MIN)) begin
			avg_n = `CIWF_AVG_MIN;
		end else if (average_samples > 8'(`CIWF_AVG_MAX)) begin
			avg_n = `CIWF_AVG_MAX;
		end else begin
			avg_n = average_samples[3:0];
		end
	end

	// offset of the channel in hand, 13 bits caps it at 8191
	assign offs_sel = pop_ch ? offset_ch2 : offset_ch1;
	// max count of the channel in hand, clamped
	assign maxc_sel = pop_ch ? ciwf_clamp_maxc(max_count_ch2) : ciwf_clamp_maxc(max_count_ch1);

	// (sum - n*offset) * 32000 / (n * maxcount), floored at zero
	assign total = acc_sum[pop_ch] + {3'h0, fifo_data[14:0]};
	assign n_offset = 17'(avg_n) * 17'(offs_sel);
	assign net = (total > {1'b0, n_offset}) ? (total - {1'b0, n_offset}) : 18'h0;
	// linear scale by the full-scale count
	// Widen before multiplying, or the products wrap at the operand width
	assign div_num = NUM_W'(net) * NUM_W'(`CIWF_FULL_SCALE);
	assign div_den = DEN_W'(avg_n) * DEN_W'(maxc_sel);
	assign last_sample = ((acc_cnt[pop_ch] + 4'h1) >= avg_n);
	assign div_start = pop && last_sample;

	// Sequential divider
	ciwf_divider #(
		.NUM_W(NUM_W),
		.DEN_W(DEN_W)
	) u_div (
		.core_clk(core_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.start(div_start),
		.numerator(div_num),
		.denominator(div_den),
		.busy(),
		.done(div_done),
		.quotient(div_quot)
	);

	// accumulate per channel until the depth is reached
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			acc_sum[0] <= '0;
			acc_sum[1] <= '0;
			acc_cnt[0] <= '0;
			acc_cnt[1] <= '0;
			work_ch <= 1'b0;
		end else if (clk_en && pop) begin
			if (last_sample) begin
				acc_sum[pop_ch] <= '0;
				acc_cnt[pop_ch] <= '0;
				work_ch <= pop_ch;
			end else begin
				acc_sum[pop_ch] <= total;
				acc_cnt[pop_ch] <= acc_cnt[pop_ch] + 4'h1;
			end
		end
	end

	// Sequencer: idle, divide, store
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state <= ciwf_pkg::CIWF_IDLE;
		end else if (clk_en) begin
			case (state)
				ciwf_pkg::CIWF_IDLE: begin
					if (div_start) begin
						state <= ciwf_pkg::CIWF_DIVIDE;
					end
				end
				ciwf_pkg::CIWF_DIVIDE: begin
					if (div_done) begin
						state <= ciwf_pkg::CIWF_STORE;
					end
				end
				ciwf_pkg::CIWF_STORE: begin
					state <= ciwf_pkg::CIWF_IDLE;
				end
				default: begin
					state <= ciwf_pkg::CIWF_IDLE;
				end
			endcase
		end
	end

	// Quotient saturated to 16 bits for flag compares
	assign full_val = (div_quot > NUM_W'(`CIWF_SAT_16)) ? `CIWF_SAT_16 : div_quot[15:0];
	// sign and low bits forced to zero
	assign data_val = ((full_val > `CIWF_SAT_15) ? `CIWF_SAT_15 : full_val) & `CIWF_DATA_MASK;

	// store the new reading and recompute its flags
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			data_word[0] <= `CIWF_ZERO_WORD;
			data_word[1] <= `CIWF_ZERO_WORD;
			cond_flags[0] <= '0;
			cond_flags[1] <= '0;
		end else if (clk_en && state == ciwf_pkg::CIWF_STORE) begin
			data_word[work_ch] <= data_val;
			cond_flags[work_ch][0] <= (full_val > 16'(`CIWF_FULL_SCALE));
			// error at or above 20.48 mA
			cond_flags[work_ch][1] <= (full_val >= `CIWF_OVER_ERR_LEVEL);
			cond_flags[work_ch][2] <= (full_val < `CIWF_UNDER_WARN_LEVEL);
			cond_flags[work_ch][3] <= (full_val == `CIWF_ZERO_WORD);
		end
	end

	// Status word assembly, one per channel
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_stat
			always_comb begin
				stat_word[gi] = `CIWF_ZERO_WORD;
				// global bit from short or overcurrent error
				stat_word[gi][`CIWF_BIT_GLOBAL] = short_sync | cond_flags[gi][1];
				// short passed on as soon as synchronised
				stat_word[gi][`CIWF_BIT_SHORT] = short_sync;
				// flags in the six low bits only
				stat_word[gi][`CIWF_BIT_OVER_WARN] = cond_flags[gi][0];
				stat_word[gi][`CIWF_BIT_OVER_ERR] = cond_flags[gi][1];
				stat_word[gi][`CIWF_BIT_UNDER_WARN] = cond_flags[gi][2];
				stat_word[gi][`CIWF_BIT_UNDER_ERR] = cond_flags[gi][3];
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			image_rd_data <= `CIWF_ZERO_WORD;
			image_rd_valid <= 1'b0;
		end else if (clk_en) begin
			image_rd_valid <= image_rd_en;
			if (image_rd_en) begin
				if (image_rd_index == `CIWF_IDX_CH1_DATA) begin
					image_rd_data <= data_word[0];
				end else if (image_rd_index == `CIWF_IDX_CH1_STAT) begin
					image_rd_data <= stat_word[0];
				end else if (image_rd_index == `CIWF_IDX_CH2_DATA) begin
					image_rd_data <= data_word[1];
				end else begin
					image_rd_data <= stat_word[1];
				end
			end
		end
	end

	property p_data_zero_bits;
		@(posedge core_clk) disable iff (!resetn)
		(data_word[0] & ~`CIWF_DATA_MASK) == 16'h0 && (data_word[1] & ~`CIWF_DATA_MASK) == 16'h0;
	endproperty
	a_data_zero_bits: assert property (p_data_zero_bits) else $error("data word bad bits");

	property p_data_read;
		@(posedge core_clk) disable iff (!resetn)
		(clk_en && image_rd_en && image_rd_index == `CIWF_IDX_CH2_DATA)
			|=> (image_rd_valid && image_rd_data == $past(data_word[1]));
	endproperty
	a_data_read: assert property (p_data_read) else $error("ch2 data read wrong");

	property p_stat_upper;
		@(posedge core_clk) disable iff (!resetn)
		(clk_en && image_rd_en && image_rd_index[0]) |=> image_rd_data[15:6] == 10'h0;
	endproperty
	a_stat_upper: assert property (p_stat_upper) else $error("status upper bits set");

	property p_global;
		@(posedge core_clk) disable iff (!resetn)
		(clk_en && image_rd_en && image_rd_index[0])
			|=> image_rd_data[0] == (image_rd_data[1] | image_rd_data[3]);
	endproperty
	a_global: assert property (p_global) else $error("global bit mismatch");

	property p_short;
		@(posedge core_clk) disable iff (!resetn)
		(clk_en && sensor_power_short_pin) [*3] ##0 (image_rd_en && image_rd_index[0])
			|=> image_rd_data[1];
	endproperty
	a_short: assert property (p_short) else $error("short not reported");

	property p_over_warn;
		@(posedge core_clk) disable iff (!resetn)
		cond_flags[0][0] |-> data_word[0] >= 16'(`CIWF_FULL_SCALE);
	endproperty
	a_over_warn: assert property (p_over_warn) else $error("warning without high reading");

	property p_over_err;
		@(posedge core_clk) disable iff (!resetn)
		cond_flags[0][1] |-> (data_word[0] == `CIWF_TOP_COUNT && cond_flags[0][0]);
	endproperty
	a_over_err: assert property (p_over_err) else $error("error without top count");

	property p_under_warn;
		@(posedge core_clk) disable iff (!resetn)
		(state == ciwf_pkg::CIWF_STORE && work_ch == 1'b0 && clk_en)
			|=> cond_flags[0][2] == (data_word[0] < `CIWF_UNDER_WARN_LEVEL);
	endproperty
	a_under_warn: assert property (p_under_warn) else $error("low warning mismatch");

	property p_under_err;
		@(posedge core_clk) disable iff (!resetn)
		cond_flags[1][3] |-> (data_word[1] == `CIWF_ZERO_WORD && cond_flags[1][2]);
	endproperty
	a_under_err: assert property (p_under_err) else $error("zero error without zero data");

	// A frozen clock enable may hold the pulse, so only enabled edges count
	property p_refresh;
		@(posedge core_clk) disable iff (!resetn)
		(clk_en && conversion_start) |=> !conversion_start;
	endproperty
	a_refresh: assert property (p_refresh) else $error("refresh pulse too long");
endmodule : ciwf_top
`default_nettype wire

// ### verification/ciwf_island_reader.sv
`default_nettype none
// Island interface model: fetches the four image words in a row on request
module ciwf_island_reader (
	input wire logic core_clk,
	input wire logic go,
	output logic image_rd_en,
	output logic [1:0] image_rd_index
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] left = 3'h0; // Reads still to issue
	initial begin
		image_rd_en = 1'b0;
		image_rd_index = 2'h0;
	end
	always @(posedge core_clk) begin
		if (left != 3'h0) begin
			image_rd_en <= 1'b1;
			image_rd_index <= 2'(3'h4 - left);
			left <= left - 3'h1;
		end else begin
			// Index churns while idle so a stale value is never trusted
			image_rd_en <= 1'b0;
			image_rd_index <= ~image_rd_index;
			if (go) begin
				left <= 3'h4;
			end
		end
	end
endmodule : ciwf_island_reader
`default_nettype wire

// ### verification/current_input_word_formatter_bench.sv
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module current_input_word_formatter_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, go = 1'b0;
	logic sample_valid = 1'b0, sample_channel = 1'b0, short_pin = 1'b0;
	logic [14:0] sample_count = 15'h0000, max1 = 15'h7D00, max2 = 15'h7D00;
	logic [12:0] off1 = 13'h0000, off2 = 13'h0000;
	logic [7:0] avg = 8'h01;
	logic sample_ready, image_rd_en, image_rd_valid, conversion_start, saw_full = 1'b0;
	logic [1:0] rd_index;
	logic [15:0] rd_data;
	logic [15:0] expq[$]; // Expected words in read order
	int mismatches = 0, checked = 0, cycles = 0, starts = 0;
	int q_now[2] = '{-1, -1}; // Expected quotient per channel, -1 before first result
	int cnt, sum;
	logic [15:0] want; // Oldest expected word, taken off once per answer
	int cnt_t[6] = '{0, 767, 768, 32000, 32008, 32767};
	ciwf_top #(.REFRESH_CYCLES(20), .FIFO_DEPTH(16)) uut (.core_clk(core_clk),
		.resetn(resetn), .clk_en(clk_en), .sample_valid(sample_valid),
		.sample_ready(sample_ready), .sample_channel(sample_channel),
		.sample_count(sample_count), .sensor_power_short_pin(short_pin),
		.offset_ch1(off1), .offset_ch2(off2), .max_count_ch1(max1), .max_count_ch2(max2),
		.average_samples(avg), .image_rd_en(image_rd_en), .image_rd_index(rd_index),
		.image_rd_data(rd_data), .image_rd_valid(image_rd_valid),
		.conversion_start(conversion_start));
	ciwf_island_reader reader (.core_clk(core_clk), .go(go), .image_rd_en(image_rd_en),
		.image_rd_index(rd_index));
	// Clock, 50 ns period
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	function automatic int calc(int s, int k, int off, int maxc);
		longint num;
		maxc = (maxc < 23800) ? 23800 : ((maxc > 32760) ? 32760 : maxc);
		num = longint'(s) - longint'(k) * off;
		if (num <= 0) return 0;
		num = num * 32000 / (k * maxc);
		return (num > 65535) ? 65535 : int'(num);
	endfunction : calc
	function automatic logic [15:0] dword(int q);
		int d;
		d = (q > 32767) ? 32767 : q;
		return (q < 0) ? 16'h0000 : (d[15:0] & 16'h7FF8);
	endfunction : dword
	function automatic logic [15:0] sword(int q);
		logic [15:0] s;
		s = 16'h0000;
		s[1] = short_pin;
		if (q >= 0) begin
			s[2] = q > 32000;
			s[3] = q >= 32768;
			s[4] = q < 768;
			s[5] = q == 0;
		end
		s[0] = s[1] | s[3];
		return s;
	endfunction : sword
	// Note the four expected words, then let the reader fetch them
	task automatic read_all();
		expq.push_back(dword(q_now[0]));
		expq.push_back(sword(q_now[0]));
		expq.push_back(dword(q_now[1]));
		expq.push_back(sword(q_now[1]));
		go = 1'b1;
		@(posedge core_clk);
		#1 go = 0;
		repeat (8) @(posedge core_clk);
		#1;
	endtask : read_all
	// Offer one sample and hold it until taken; valid stays up
	task automatic send(input logic ch, input int c);
		logic ok;
		sample_channel = ch;
		sample_count = c[14:0];
		sample_valid = 1'b1;
		do begin
			ok = (sample_ready === 1'b1);
			@(posedge core_clk);
			#1;
		end while (!ok);
	endtask : send
	// One averaged group of k samples on a channel, random counts when k > 1 else the preset cnt, then settle
	task automatic conv(input logic ch, input int k);
		sum = 0;
		for (int i = 0; i < k; i++) begin
			if (k > 1) cnt = $urandom_range(32767, 0);
			sum += cnt;
			send(ch, cnt);
		end
		sample_valid = 1'b0;
		repeat (60) @(posedge core_clk);
		#1;
		q_now[ch] = ch ? calc(sum, k, off2, max2) : calc(sum, k, off1, max1);
	endtask : conv
	// Result watcher pops the oldest note for each read answer
	always @(posedge core_clk) begin
		if (image_rd_valid === 1'b1) begin
			if (expq.size() == 0) `CHK(1'b1, 1'b0)
			else begin
				want = expq.pop_front();
				`CHK(rd_data, want)
			end
		end
	end
	// Refresh pulses and full FIFO seen
	always @(posedge core_clk) begin
		if (conversion_start === 1'b1 && clk_en === 1'b1) starts++;
		if (resetn && sample_valid && sample_ready === 1'b0) saw_full = 1'b1;
	end
	// Hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		if (mismatches == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		void'($urandom(68524));
		repeat (16) @(posedge core_clk);
		#1 resetn = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		read_all();
		foreach (cnt_t[i]) begin
			cnt = cnt_t[i];
			conv(1'b0, 1);
			read_all();
		end
		max1 = 15'h3A98;
		cnt = 32767;
		conv(1'b0, 1);
		read_all();
		off1 = 13'h1FFF;
		foreach (cnt_t[i]) begin
			cnt = cnt_t[i];
			conv(1'b0, 1);
			read_all();
		end
		// random channel 2 calibration and counts
		repeat (4) begin
			max2 = 15'($urandom_range(32760, 23800));
			off2 = 13'($urandom_range(8191, 0));
			cnt = $urandom_range(32767, 0);
			conv(1'b1, 1);
			read_all();
		end
		cnt = 0;
		conv(1'b1, 1);
		read_all();
		off1 = 13'h0000;
		avg = 8'h03;
		conv(1'b0, 3);
		read_all();
		avg = 8'h14;
		conv(1'b0, 8);
		read_all();
		avg = 8'h01;
		short_pin = 1'b1;
		repeat (3) @(posedge core_clk);
		#1 read_all();
		short_pin = 1'b0;
		repeat (3) @(posedge core_clk);
		#1 read_all();
		// FIFO fills under back-pressure; last word wins
		for (int i = 0; i < 20; i++) begin
			cnt = $urandom_range(32767, 0);
			send(1'b1, cnt);
		end
		sample_valid = 1'b0;
		repeat (900) @(posedge core_clk);
		#1 q_now[1] = calc(cnt, 1, off2, max2);
		read_all();
		`CHK(saw_full, 1'b1)
		// Mid-run reset clears both words and all flags
		resetn = 1'b0;
		repeat (2) @(posedge core_clk);
		#1 resetn = 1'b1;
		q_now = '{-1, -1};
		read_all();
		// refresh period over enabled edges; a frozen stretch adds no pulse
		starts = 0;
		repeat (100) @(posedge core_clk);
		#1 clk_en = 1'b0;
		repeat (40) @(posedge core_clk);
		#1 clk_en = 1'b1;
		repeat (100) @(posedge core_clk);
		#1;
		`CHK(starts, 10)
		`CHK(expq.size(), 0)
		end_of_test();
	end
endmodule : current_input_word_formatter_bench
`default_nettype wire
